// ==== include/uart_flow_pkg.sv ====
// Package with register map, field positions and reset values of the flow block
package uart_flow_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_FEATURE   = 8'h00;
  localparam logic [7:0] OFS_MODEM     = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;
  localparam logic [7:0] OFS_THRESH    = 8'h0c;
  localparam logic [7:0] OFS_CHARS     = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_LINE      = 8'h18;

  // Field positions in enhanced_feature_control
  localparam int FEAT_TX_LSB    = 2;
  localparam int FEAT_RX_LSB    = 0;
  localparam int FEAT_SPECIAL   = 5;
  localparam int FEAT_AUTO_RTS  = 6;
  localparam int FEAT_AUTO_CTS  = 7;

  // Other single-bit fields
  localparam int MODEM_RESUME_ANY = 5;
  localparam int MASK_PAUSE_EN    = 5;
  localparam int STAT_HALTED      = 0;
  localparam int STAT_PAUSE_SENT  = 1;
  localparam int STAT_SPECIAL     = 2;
  localparam int STAT_PAUSE_FLAG  = 4;

  // Byte positions of the four flow characters in the chars register
  localparam int CH_RESUME1 = 0;
  localparam int CH_RESUME2 = 8;
  localparam int CH_PAUSE1  = 16;
  localparam int CH_PAUSE2  = 24;

  // Threshold nibbles count in steps of four bytes
  localparam int THR_HALT_LSB   = 0;
  localparam int THR_RESUME_LSB = 4;
  localparam int THR_SHIFT      = 2;

  // Selector codes shared by the transmit and receive fields
  localparam logic [1:0] SEL_NONE   = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_FIRST  = 2'h2;
  localparam logic [1:0] SEL_BOTH   = 2'h3;

  // Word length codes
  localparam logic [1:0] WL_5 = 2'h0;
  localparam logic [1:0] WL_6 = 2'h1;
  localparam logic [1:0] WL_7 = 2'h2;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [31:0] RST_CHARS = 32'h0000_0000;
  localparam logic [1:0]  RST_WLEN  = 2'h3;

endpackage : uart_flow_pkg

// ==== logic/uart_flow_control.sv ====
// Automatic transmit flow control for one UART channel with APB registers
`timescale 1ns/100ps
module uart_flow_control
  import uart_flow_pkg::*;
#(
  parameter int LEVEL_W = 7
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               cts_n,
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_data,
  input  wire logic               rx_err,
  input  wire logic [LEVEL_W-1:0] rx_level,
  output logic                    fifo_wr_valid,
  output logic [7:0]              fifo_wr_data,
  output logic                    fifo_wr_err,
  input  wire logic               txf_valid,
  input  wire logic [7:0]         txf_data,
  output logic                    txf_pop,
  input  wire logic               tx_busy,
  output logic                    tx_start,
  output logic [7:0]              tx_char,
  output logic                    auto_rts_en,
  output logic                    irq
);

  // Mask of the bits that the current word length sends
  function automatic logic [7:0] word_mask(input logic [1:0] wl);
    logic [7:0] m;
    m = 8'hff;
    if (wl == WL_5)
      m = 8'h1f;
    else if (wl == WL_6)
      m = 8'h3f;
    else if (wl == WL_7)
      m = 8'h7f;
    return m;
  endfunction : word_mask

  // Threshold nibble scaled to a receive level
  function automatic logic [LEVEL_W-1:0] thr_level(input logic [3:0] nib);
    logic [LEVEL_W+3:0] v;
    v = {{LEVEL_W{1'b0}}, nib} << THR_SHIFT;
    return v[LEVEL_W-1:0];
  endfunction : thr_level

  // Software registers
  logic [7:0]  feature_r;
  logic [7:0]  modem_r;
  logic [7:0]  mask_r;
  logic [7:0]  thresh_r;
  logic [31:0] chars_r;
  logic [1:0]  wlen_r;

  // Receive and transmit state
  logic        halted_r,     halted_nxt;
  logic        flag_r,       flag_nxt;
  logic        special_r,    special_nxt;
  logic        held_v_r,     held_v_nxt;
  logic        held_pause_r, held_pause_nxt;
  logic [7:0]  held_d_r,     held_d_nxt;
  logic        spill_v_r,    spill_v_nxt;
  logic [7:0]  spill_d_r,    spill_d_nxt;
  logic        spill_e_r,    spill_e_nxt;
  logic        wr_v_r,       wr_v_nxt;
  logic [7:0]  wr_d_r,       wr_d_nxt;
  logic        wr_e_r,       wr_e_nxt;
  logic        pause_sent_r;
  logic [1:0]  sent_sel_r;
  logic        fc_act_r;
  logic        fc_pause_r;
  logic [1:0]  fc_sel_r;
  logic        fc_idx_r;
  logic        start_r;
  logic [7:0]  char_r;
  logic [31:0] rdata_r;

  // Bus decode
  wire         setup_rd  = psel & ~penable & ~pwrite;
  wire         acc       = psel & penable;
  wire         hit_feat  = (paddr == OFS_FEATURE);
  wire         hit_modem = (paddr == OFS_MODEM);
  wire         hit_mask  = (paddr == OFS_IRQ_MASK);
  wire         hit_thr   = (paddr == OFS_THRESH);
  wire         hit_chars = (paddr == OFS_CHARS);
  wire         hit_stat  = (paddr == OFS_STATUS);
  wire         hit_line  = (paddr == OFS_LINE);
  wire         mapped    = hit_feat | hit_modem | hit_mask | hit_thr |
                           hit_chars | hit_stat | hit_line;
  wire         wr_en     = acc & pwrite & mapped;
  wire         stat_rd   = acc & ~pwrite & hit_stat;
  wire [7:0]   status_v  = {3'h0, flag_r, 1'b0, special_r,
                            pause_sent_r, halted_r};
  wire [31:0]  rd_mux    = hit_feat  ? {24'h0, feature_r} :
                           hit_modem ? {24'h0, modem_r} :
                           hit_mask  ? {24'h0, mask_r} :
                           hit_thr   ? {24'h0, thresh_r} :
                           hit_chars ? chars_r :
                           hit_stat  ? {24'h0, status_v} :
                           hit_line  ? {30'h0, wlen_r} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = rdata_r;

  // Configuration fields
  wire [1:0]  tx_sel     = feature_r[FEAT_TX_LSB +: 2];
  wire [1:0]  rx_sel     = feature_r[FEAT_RX_LSB +: 2];
  wire        auto_cts   = feature_r[FEAT_AUTO_CTS];
  wire        special_en = feature_r[FEAT_SPECIAL];
  wire        resume_any = modem_r[MODEM_RESUME_ANY];
  wire [7:0]  wmask      = word_mask(wlen_r);
  wire [7:0]  resume1    = chars_r[CH_RESUME1 +: 8];
  wire [7:0]  resume2    = chars_r[CH_RESUME2 +: 8];
  wire [7:0]  pause1     = chars_r[CH_PAUSE1 +: 8];
  wire [7:0]  pause2     = chars_r[CH_PAUSE2 +: 8];
  assign auto_rts_en = feature_r[FEAT_AUTO_RTS];

  // Character under inspection: a spilled one first, else the receiver's
  wire        cur_v   = spill_v_r | rx_valid;
  wire [7:0]  cur_d   = spill_v_r ? spill_d_r : rx_data;
  wire        cur_e   = spill_v_r ? spill_e_r : rx_err;
  wire        cur_ok  = cur_v & ~cur_e & (rx_sel != SEL_NONE);
  wire        is_p1   = (cur_d & wmask) == (pause1 & wmask);
  wire        is_p2   = (cur_d & wmask) == (pause2 & wmask);
  wire        is_r1   = (cur_d & wmask) == (resume1 & wmask);
  wire        is_r2   = (cur_d & wmask) == (resume2 & wmask);
  wire        seq     = (rx_sel == SEL_BOTH) &
                        ((tx_sel == SEL_BOTH) | (tx_sel == SEL_NONE));
  wire        either  = (rx_sel == SEL_BOTH) & ~seq;
  wire        use1    = (rx_sel == SEL_FIRST) | either;
  wire        use2    = (rx_sel == SEL_SECOND) | either;
  wire        spec_hit = cur_v & ~cur_e & special_en & is_p2;

  // Receive matching, pause and resume recognition
  always_comb
  begin
    halted_nxt     = halted_r;
    flag_nxt       = flag_r;
    special_nxt    = special_r;
    held_v_nxt     = held_v_r;
    held_pause_nxt = held_pause_r;
    held_d_nxt     = held_d_r;
    spill_v_nxt    = 1'b0;
    spill_d_nxt    = spill_d_r;
    spill_e_nxt    = spill_e_r;
    wr_v_nxt       = 1'b0;
    wr_d_nxt       = wr_d_r;
    wr_e_nxt       = wr_e_r;
    if (stat_rd && special_r)
    begin
      flag_nxt    = 1'b0;
      special_nxt = 1'b0;
    end
    if (cur_v)
    begin
      // Default: store the character as plain data
      wr_v_nxt = 1'b1;
      wr_d_nxt = cur_d;
      wr_e_nxt = cur_e;
      if (halted_r && resume_any)
        halted_nxt = 1'b0;
      if (spec_hit)
      begin
        flag_nxt    = 1'b1;
        special_nxt = 1'b1;
      end
      else if (seq && held_v_r)
      begin
        held_v_nxt = 1'b0;
        if (cur_ok && held_pause_r && is_p2)
        begin
          wr_v_nxt    = 1'b0;
          halted_nxt  = 1'b1;
          flag_nxt    = 1'b1;
          special_nxt = 1'b0;
        end
        else if (cur_ok && !held_pause_r && is_r2)
        begin
          wr_v_nxt   = 1'b0;
          halted_nxt = 1'b0;
          flag_nxt   = special_r ? flag_nxt : 1'b0;
        end
        else
        begin
          // Lone first character: store it, look at the new one next cycle
          wr_d_nxt    = held_d_r;
          wr_e_nxt    = 1'b0;
          spill_v_nxt = 1'b1;
          spill_d_nxt = cur_d;
          spill_e_nxt = cur_e;
        end
      end
      else if (seq && cur_ok && is_p1)
      begin
        wr_v_nxt       = 1'b0;
        held_v_nxt     = 1'b1;
        held_pause_nxt = 1'b1;
        held_d_nxt     = cur_d;
      end
      else if (seq && cur_ok && is_r1)
      begin
        wr_v_nxt = 1'b0;
        if (!(halted_r && resume_any))
        begin
          held_v_nxt     = 1'b1;
          held_pause_nxt = 1'b0;
          held_d_nxt     = cur_d;
        end
        // Otherwise taken as any-character resume; second one is data
      end
      else if (!seq && cur_ok && ((use1 && is_p1) || (use2 && is_p2)))
      begin
        wr_v_nxt    = 1'b0;
        halted_nxt  = 1'b1;
        flag_nxt    = 1'b1;
        special_nxt = 1'b0;
      end
      else if (!seq && cur_ok && ((use1 && is_r1) || (use2 && is_r2)))
      begin
        wr_v_nxt   = 1'b0;
        halted_nxt = 1'b0;
        flag_nxt   = special_r ? flag_nxt : 1'b0;
      end
    end
    else if (held_v_r && !seq)
    begin
      // Mode left sequential matching: release the held character
      held_v_nxt = 1'b0;
      wr_v_nxt   = 1'b1;
      wr_d_nxt   = held_d_r;
      wr_e_nxt   = 1'b0;
    end
  end

  assign fifo_wr_valid = wr_v_r;
  assign fifo_wr_data  = wr_d_r;
  assign fifo_wr_err   = wr_e_r;
  assign irq = flag_r & mask_r[MASK_PAUSE_EN];

  // Transmit side decisions
  wire        idle     = ~tx_busy & ~start_r;
  wire        cts_ok   = ~auto_cts | ~cts_n;
  wire        can_go   = idle & cts_ok;
  wire        level_hi = rx_level > thr_level(thresh_r[THR_HALT_LSB +: 4]);
  wire        level_lo = rx_level <= thr_level(thresh_r[THR_RESUME_LSB +: 4]);
  wire        need_res = pause_sent_r &
                         (level_lo | (tx_sel == SEL_NONE) |
                          (tx_sel != sent_sel_r));
  wire        need_pau = ~pause_sent_r & (tx_sel != SEL_NONE) &
                         level_hi;
  wire        fc_go    = fc_act_r & can_go;
  wire        fc_last  = (fc_sel_r != SEL_BOTH) | fc_idx_r;
  wire        use_sec  = fc_idx_r | (fc_sel_r == SEL_SECOND);
  wire [7:0]  fc_char  = fc_pause_r ? (use_sec ? pause2 : pause1) :
                                      (use_sec ? resume2 : resume1);
  assign txf_pop  = can_go & ~fc_act_r & txf_valid & ~halted_r;
  assign tx_start = start_r;
  assign tx_char  = char_r;

  // Flow character sequencer and transmit start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fc_act_r     <= 1'b0;
      fc_pause_r   <= 1'b0;
      fc_sel_r     <= SEL_NONE;
      fc_idx_r     <= 1'b0;
      pause_sent_r <= 1'b0;
      sent_sel_r   <= SEL_NONE;
      start_r      <= 1'b0;
      char_r       <= RST_BYTE;
    end
    else
    begin
      start_r <= fc_go | txf_pop;
      if (fc_go)
        char_r <= fc_char & wmask;
      else if (txf_pop)
        char_r <= txf_data & wmask;
      if (!fc_act_r && (need_res || need_pau))
      begin
        fc_act_r   <= 1'b1;
        fc_pause_r <= need_pau;
        fc_sel_r   <= need_pau ? tx_sel : sent_sel_r;
        fc_idx_r   <= 1'b0;
      end
      else if (fc_go)
      begin
        fc_idx_r <= 1'b1;
        if (fc_last)
        begin
          fc_act_r     <= 1'b0;
          pause_sent_r <= fc_pause_r;
          sent_sel_r   <= fc_sel_r;
        end
      end
    end
  end

  // Receive state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halted_r     <= 1'b0;
      flag_r       <= 1'b0;
      special_r    <= 1'b0;
      held_v_r     <= 1'b0;
      held_pause_r <= 1'b0;
      held_d_r     <= RST_BYTE;
      spill_v_r    <= 1'b0;
      spill_d_r    <= RST_BYTE;
      spill_e_r    <= 1'b0;
      wr_v_r       <= 1'b0;
      wr_d_r       <= RST_BYTE;
      wr_e_r       <= 1'b0;
    end
    else
    begin
      halted_r     <= halted_nxt;
      flag_r       <= flag_nxt;
      special_r    <= special_nxt;
      held_v_r     <= held_v_nxt;
      held_pause_r <= held_pause_nxt;
      held_d_r     <= held_d_nxt;
      spill_v_r    <= spill_v_nxt;
      spill_d_r    <= spill_d_nxt;
      spill_e_r    <= spill_e_nxt;
      wr_v_r       <= wr_v_nxt;
      wr_d_r       <= wr_d_nxt;
      wr_e_r       <= wr_e_nxt;
    end
  end

  // APB register writes and read data capture in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      feature_r <= RST_BYTE;
      modem_r   <= RST_BYTE;
      mask_r    <= RST_BYTE;
      thresh_r  <= RST_BYTE;
      chars_r   <= RST_CHARS;
      wlen_r    <= RST_WLEN;
      rdata_r   <= RST_CHARS;
    end
    else
    begin
      if (setup_rd)
        rdata_r <= rd_mux;
      if (wr_en && hit_feat)
        feature_r <= pwdata[7:0];
      if (wr_en && hit_modem)
        modem_r <= pwdata[7:0];
      if (wr_en && hit_mask)
        mask_r <= pwdata[7:0];
      if (wr_en && hit_thr)
        thresh_r <= pwdata[7:0];
      if (wr_en && hit_chars)
        chars_r <= pwdata;
      if (wr_en && hit_line)
        wlen_r <= pwdata[1:0];
    end
  end

endmodule : uart_flow_control

// ==== bench/uart_flow_control_asserts.sv ====
// Port-level checker for the UART flow control block
`timescale 1ns/100ps
module uart_flow_control_asserts
  import uart_flow_pkg::*;
(
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        cts_n,
  input logic        rx_valid,
  input logic [7:0]  rx_data,
  input logic        rx_err,
  input logic        fifo_wr_valid,
  input logic [7:0]  fifo_wr_data,
  input logic        fifo_wr_err,
  input logic        txf_valid,
  input logic [7:0]  txf_data,
  input logic        txf_pop,
  input logic        tx_busy,
  input logic        tx_start,
  input logic [7:0]  tx_char,
  input logic        auto_rts_en,
  input logic        irq
);
  logic [7:0]  feat_r;
  logic [7:0]  mask_r;
  logic [31:0] chars_r;
  logic [1:0]  wl_r;
  // Shadow decode of writes and character matches
  wire         wr    = psel && penable && pwrite;
  wire  [7:0]  wmask = 8'hff >> (2'h3 - wl_r);
  wire         rx_ok = rx_valid && !rx_err && !feat_r[FEAT_SPECIAL]
                       && feat_r[1:0] == SEL_FIRST;
  wire         p1    = rx_ok && ((rx_data ^ chars_r[23:16]) & wmask) == 8'h00;
  wire         r1    = rx_ok && ((rx_data ^ chars_r[7:0]) & wmask) == 8'h00;

  // Shadow copies of the settings this checker depends on
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      feat_r  <= 8'h00;
      mask_r  <= 8'h00;
      chars_r <= 32'h0000_0000;
      wl_r    <= RST_WLEN;
    end
    else if (wr)
    begin
      if (paddr == OFS_FEATURE) feat_r <= pwdata[7:0];
      if (paddr == OFS_IRQ_MASK) mask_r <= pwdata[7:0];
      if (paddr == OFS_CHARS) chars_r <= pwdata;
      if (paddr == OFS_LINE) wl_r <= pwdata[1:0];
    end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cts_gate: assert property (
    tx_start |-> !$past(feat_r[FEAT_AUTO_CTS]) || !$past(cts_n))
    else $error("character started while clear-to-send was high");
  a_start_idle: assert property (
    tx_start |-> !$past(tx_busy))
    else $error("character started while shifter busy");
  a_pop_ready: assert property (
    txf_pop |-> txf_valid && !tx_busy && !tx_start)
    else $error("fifo popped while not idle or empty");
  a_pop_start: assert property (
    txf_pop |=> tx_start && tx_char == $past(txf_data & wmask))
    else $error("popped byte not started next cycle");
  a_irq_mask: assert property (
    !mask_r[MASK_PAUSE_EN] |-> !irq)
    else $error("interrupt high while masked");
  a_pause_irq: assert property (
    p1 && mask_r[MASK_PAUSE_EN] |=> irq)
    else $error("pause character did not raise interrupt");
  a_pause_kept: assert property (
    p1 |=> !fifo_wr_valid [*2])
    else $error("pause character stored as data");
  a_resume_clr: assert property (
    r1 |=> !irq)
    else $error("resume character left flag set");
  a_err_stored: assert property (
    rx_valid && rx_err && feat_r[1:0] != SEL_BOTH && wl_r == 2'h3
    |=> fifo_wr_valid && fifo_wr_err && fifo_wr_data == $past(rx_data))
    else $error("errored character not stored");
  a_rts_bit: assert property (
    wr && paddr == OFS_FEATURE |=> auto_rts_en == $past(pwdata[FEAT_AUTO_RTS]))
    else $error("auto request-to-send enable wrong");
endmodule : uart_flow_control_asserts

// ==== bench/remote_uart_model.sv ====
// Remote party: serial shifter timing and clear-to-send control
`timescale 1ns/100ps
module remote_uart_model #(
  parameter int CHAR_CYC = 20
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tx_start,
  input  wire logic blk,
  output logic      tx_busy,
  output logic      cts_n
);
  logic [7:0] cnt_r;

  // Character timing, and a block that only lands before the last stop bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_r   <= 8'h00;
      tx_busy <= 1'b0;
      cts_n   <= 1'b0;
    end
    else
    begin
      if (tx_start)
      begin
        tx_busy <= 1'b1;
        cnt_r   <= 8'(CHAR_CYC);
      end
      else if (cnt_r > 8'h01) cnt_r <= cnt_r - 8'h01;
      else
      begin
        cnt_r   <= 8'h00;
        tx_busy <= 1'b0;
      end
      if (!blk) cts_n <= 1'b0;
      else if (!tx_busy || cnt_r > 8'h04) cts_n <= 1'b1;
    end
endmodule : remote_uart_model

// ==== bench/uart_flow_control_tb_top.sv ====
// Self-checking testbench for the UART flow control block
`timescale 1ns/100ps
module uart_flow_control_tb_top;
  import uart_flow_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, blk = 1'b0, er;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic        rx_valid = 1'b0, rx_err = 1'b0, txf_valid = 1'b0, cts_n, irq;
  logic        fifo_wr_valid, fifo_wr_err, txf_pop, tx_busy, tx_start, rts;
  logic [7:0]  paddr = 8'h00, rx_data = 8'h00, txf_data = 8'h00;
  logic [7:0]  fifo_wr_data, tx_char;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [6:0]  rx_level = 7'h00;
  logic [1:0]  s;
  logic [7:0]  txq[$], exp_tx[$];
  logic [8:0]  exp_rx[$];
  int          error_cnt = 0, n_checks = 0, n_tx = 0, n0, seed = 32'h2f73;

  always #20 pclk = ~pclk;

  uart_flow_control u_uart_flow_control (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cts_n(cts_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
    .rx_level(rx_level), .fifo_wr_valid(fifo_wr_valid),
    .fifo_wr_data(fifo_wr_data), .fifo_wr_err(fifo_wr_err),
    .txf_valid(txf_valid), .txf_data(txf_data), .txf_pop(txf_pop),
    .tx_busy(tx_busy), .tx_start(tx_start), .tx_char(tx_char),
    .auto_rts_en(rts), .irq(irq));
  remote_uart_model u_remote_uart_model (.pclk(pclk), .presetn(presetn),
    .tx_start(tx_start), .blk(blk), .tx_busy(tx_busy), .cts_n(cts_n));

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && k++ < 50);
    // A wait that runs out is a mismatch
    if (pready !== 1'b1) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rx_send(input logic [7:0] d, input logic e, st);
    if (st) exp_rx.push_back({e, d});
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_err <= e;
    rx_data <= d;
    @(posedge pclk);
    rx_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : rx_send

  task automatic push_tx(input logic [7:0] d, m);
    txq.push_back(d);
    exp_tx.push_back(d & m);
  endtask : push_tx

  task automatic drain;
    int k;
    k = 0;
    while (exp_tx.size() + exp_rx.size() > 0 && k++ < 2000) @(posedge pclk);
    chk("pending", 0, exp_tx.size() + exp_rx.size());
  endtask : drain

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Transmit fifo model and output monitor against the noted results
  always @(posedge pclk)
  begin
    if (txf_pop) void'(txq.pop_front());
    txf_valid <= txq.size() > 0;
    txf_data <= txq.size() > 0 ? txq[0] : 8'h00;
    if (tx_start) n_tx++;
    if (tx_start && exp_tx.size() == 0) chk("tx_extra", 0, 1);
    else if (tx_start) chk("tx_char", exp_tx.pop_front(), tx_char);
    if (fifo_wr_valid && exp_rx.size() == 0) chk("rx_extra", 0, 1);
    else if (fifo_wr_valid)
      chk("fifo_wr", exp_rx.pop_front(), {fifo_wr_err, fifo_wr_data});
  end

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    end_sim;
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_FEATURE, 32'h0);
    chk("feature_rst", 0, rd);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 1, er);
    // Auto-CTS off: random bytes go out despite CTS high, each word length
    blk <= 1'b1;
    for (int w = 0; w < 4; w++)
    begin
      apb(1'b1, OFS_LINE, w);
      push_tx(8'($random(seed)), 8'hff >> (3 - w));
      drain;
    end
    blk <= 1'b0;
    apb(1'b1, OFS_FEATURE, 32'h40);
    // The write lands at the access edge; look one edge later
    @(posedge pclk);
    chk("auto_rts", 1, rts);
    // Auto-CTS: block mid-character, in-flight one ends, next is held
    apb(1'b1, OFS_FEATURE, 32'h80);
    n0 = n_tx;
    repeat (3) push_tx(8'($random(seed)), 8'hff);
    while (n_tx == n0) @(posedge pclk);
    blk <= 1'b1;
    repeat (120) @(posedge pclk);
    chk("cts_hold", n0 + 1, n_tx);
    blk <= 1'b0;
    drain;
    // Single pair matching: pause, errored resume, real resume
    apb(1'b1, OFS_CHARS, 32'h1413_1211);
    apb(1'b1, OFS_IRQ_MASK, 32'h20);
    apb(1'b1, OFS_FEATURE, 32'h02);
    rx_send(8'h13, 1'b0, 1'b0);
    chk("irq_pause", 1, irq);
    n0 = n_tx;
    push_tx(8'h5a, 8'hff);
    rx_send(8'h41, 1'b0, 1'b1);
    rx_send(8'h11, 1'b1, 1'b1);
    repeat (60) @(posedge pclk);
    chk("halted", n0, n_tx);
    rx_send(8'h11, 1'b0, 1'b0);
    drain;
    chk("irq_resume", 0, irq);
    // Resume on any character
    apb(1'b1, OFS_MODEM, 32'h20);
    rx_send(8'h13, 1'b0, 1'b0);
    push_tx(8'h5b, 8'hff);
    rx_send(8'h42, 1'b0, 1'b1);
    drain;
    // Resume-any leaves the flag; a real resume clears it
    rx_send(8'h11, 1'b0, 1'b0);
    chk("irq_clr", 0, irq);
    apb(1'b1, OFS_MODEM, 32'h0);
    // Sequential pairs: lone first char is data, full pairs act
    apb(1'b1, OFS_FEATURE, 32'h03);
    rx_send(8'h13, 1'b0, 1'b1);
    rx_send(8'h20, 1'b0, 1'b1);
    rx_send(8'h13, 1'b0, 1'b0);
    rx_send(8'h14, 1'b0, 1'b0);
    chk("irq_pair", 1, irq);
    push_tx(8'h5c, 8'hff);
    rx_send(8'h11, 1'b0, 1'b0);
    rx_send(8'h12, 1'b0, 1'b0);
    drain;
    // Either character of a kind accepted
    apb(1'b1, OFS_FEATURE, 32'h0b);
    rx_send(8'h14, 1'b0, 1'b0);
    chk("irq_either", 1, irq);
    rx_send(8'h12, 1'b0, 1'b0);
    chk("irq_either_clr", 0, irq);
    // Special character flags, is stored, does not halt, read clears
    apb(1'b1, OFS_FEATURE, 32'h22);
    rx_send(8'h14, 1'b0, 1'b1);
    chk("irq_special", 1, irq);
    push_tx(8'h5d, 8'hff);
    drain;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("flag_bit", 1, rd[STAT_PAUSE_FLAG]);
    repeat (2) @(posedge pclk);
    chk("irq_read_clr", 0, irq);
    // Threshold pause/resume for each transmit selection other than none
    apb(1'b1, OFS_THRESH, 32'h12);
    for (int i = 1; i < 4; i++)
    begin
      s = i[1:0];
      apb(1'b1, OFS_FEATURE, {28'h0, s, 2'b00});
      rx_level <= 7'd9;
      if (s[1]) exp_tx.push_back(8'h13);
      if (s[0]) exp_tx.push_back(8'h14);
      drain;
      rx_level <= 7'd4;
      if (s[1]) exp_tx.push_back(8'h11);
      if (s[0]) exp_tx.push_back(8'h12);
      drain;
    end
    // First-character transmit selection with a high level sends the pause
    apb(1'b1, OFS_FEATURE, 32'h08);
    rx_level <= 7'd9;
    exp_tx.push_back(8'h13);
    drain;
    // New selection while paused: old resume, then new pause
    apb(1'b1, OFS_FEATURE, 32'h04);
    exp_tx.push_back(8'h11);
    exp_tx.push_back(8'h14);
    drain;
    apb(1'b1, OFS_FEATURE, 32'h0);
    exp_tx.push_back(8'h12);
    drain;
    rx_level <= 7'd0;
    end_sim;
  end
endmodule : uart_flow_control_tb_top

bind uart_flow_control uart_flow_control_asserts u_asserts (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .cts_n(cts_n), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_err(rx_err), .fifo_wr_valid(fifo_wr_valid),
  .fifo_wr_data(fifo_wr_data), .fifo_wr_err(fifo_wr_err),
  .txf_valid(txf_valid), .txf_data(txf_data), .txf_pop(txf_pop),
  .tx_busy(tx_busy), .tx_start(tx_start), .tx_char(tx_char),
  .auto_rts_en(auto_rts_en), .irq(irq));
